// >>> hdl/dar_regs.svh
// register indices, bus decode addresses and field positions of the relocation map
`ifndef DAR_REGS_SVH
`define DAR_REGS_SVH

`define DAR_IDX_MAP_LAST  7'h3f
`define DAR_IDX_LMA_LO    7'h40
`define DAR_IDX_LMA_HI    7'h41
`define DAR_IDX_STATUS3   7'h42
`define DAR_MAPEN_BIT     5
`define DAR_FORCE_BIT     6
`define DAR_CTLHI_BIT     15
`define DAR_CTLLO_BIT     14
`define DAR_IO_PAGE       5'h1f
`define DAR_LIMIT_ZERO    5'h00
`define DAR_LIMIT_TOP     5'h1f
`define DAR_IO_HIGH       4'hf
`define DAR_LOW_HIGH      4'h0
`define DAR_MAPWIN_FIRST  18'h3_f080
`define DAR_MAPWIN_LAST   18'h3_f0ff
`define DAR_LMA_BUS_LO    18'h3_ffdc
`define DAR_LMA_BUS_HI    18'h3_ffde
`define DAR_RST_LIMIT     5'h00

`endif

// >>> hdl/dar_pkg.sv
// types shared by the relocation map design
package dar_pkg;

  typedef struct packed {
    logic [17:0] addr;
    logic [1:0]  ctl;
    logic        msyn;
  } dar_bus_t;

  typedef enum logic [1:0] {
    DAR_IDLE = 2'b00,
    DAR_LOOK = 2'b01,
    DAR_SYNC = 2'b10
  } dar_fsm_t;

  typedef enum logic [1:0] {
    DAR_RD_HOLD  = 2'b00,
    DAR_RD_MAPLO = 2'b01,
    DAR_RD_MAPHI = 2'b10
  } dar_rdsel_t;

  typedef struct packed {
    dar_fsm_t    fsm;
    dar_bus_t    bus1;
    dar_bus_t    bus2;
    logic [4:0]  lo1;
    logic [4:0]  lo2;
    logic [4:0]  up1;
    logic [4:0]  up2;
    logic [21:0] memAddr;
    logic [1:0]  memCtl;
    logic        memMsyn;
    logic [21:0] last_mapped_address;
    logic [1:0]  lmaCtl;
    logic        forceDef;
    logic        mapEn;
    dar_rdsel_t  rdSel;
    logic [15:0] rdHold;
  } dar_state_t;

endpackage : dar_pkg

// >>> hdl/dar_map_mem.sv
// map base store: one half-word write port, two registered read ports
`timescale 1ns/100ps
module dar_map_mem #(
  parameter int ENTRIES = 32,
  parameter int IDX_W   = 5
) (
  input  wire logic             clk,      // system clock
  input  wire logic             rst,      // sync reset
  input  wire logic             wrEn,     // write one half
  input  wire logic             wrHi,     // high half selected
  input  wire logic [IDX_W-1:0] wrIdx,    // entry written
  input  wire logic [15:0]      wrData,   // write word
  input  wire logic [IDX_W-1:0] rdIdxA,   // relocation lookup
  output logic      [21:1]      rdDataA,  // base for lookup
  input  wire logic [IDX_W-1:0] rdIdxB,   // software read
  output logic      [21:1]      rdDataB   // base for software
);

  logic [21:1] baseMem [ENTRIES];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        baseMem[i] <= '0;
      end
      rdDataA <= '0;
      rdDataB <= '0;
    end else begin
      if (wrEn && wrHi) begin
        baseMem[wrIdx][21:16] <= wrData[5:0];
      end else if (wrEn) begin
        baseMem[wrIdx][15:1] <= wrData[15:1];
      end
      rdDataA <= baseMem[rdIdxA];
      rdDataB <= baseMem[rdIdxB];
    end
  end

endmodule : dar_map_mem

// >>> hdl/dar_reloc_map.sv
// address relocation map between the 18-bit device bus and the 22-bit memory bus
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "dar_regs.svh"

// Behaviour
// R1: relocate 18-bit bus addresses into 22-bit memory addresses when enabled.
// R2: map bases are 21 bits (21:1); bit 0 always reads zero.
// R3: bus address bits 17:13 select the map entry.
// R4: base bits 21:1 plus bus bits 12:1 through a full adder.
// R5: bus bit 0 and both transfer-control bits pass unchanged.
// R6: drive physical address to memory and capture it in last-mapped-address.
// R7: relocation only while map-enable bit 5 of status register three set.
// R8: thirty-second entry is read/write but never supplies a base.
// R9: lower window grows up from zero, upper window down from 124K.
// R10: lower limit is first excluded page; zero means no lower window.
// R11: upper limit is first upper-window page; 124K means no upper window.
// R12: both 0K, both 124K, or lower above upper: relocate all but I/O page.
// R13: bus I/O page always reaches memory I/O page; the code does not pass map or last-mapped-address register accesses to memory.
// R14: force-default bit makes limits behave as all jumpers removed.
// R15: all 32 map entries readable and writable from the register port.
// R16: with map enabled, memory sync waits for the relocated address.
// R17: accesses to map or last-mapped-address registers never sync memory.
// R18: force bit is high-word bit 6; bits 15:14 control; 5:0 address 21:16.
// R19: unrelocated addresses outside the I/O page pass with upper physical bits zero.
module dar_reloc_map
  import dar_pkg::*;
(
  input  wire logic     clk,         // 200 MHz system clock
  input  wire logic     rst,         // sync reset, active high
  input  wire dar_bus_t busIn,       // bus address, control, master sync pins
  input  wire logic [4:0] lowerLimit,  // lower limit jumpers, 4K pages
  input  wire logic [4:0] upperLimit,  // upper limit jumpers, 4K pages
  output logic [21:0]   memAddr,     // physical address to memory
  output logic [1:0]    memCtl,      // transfer control to memory
  output logic          memMsyn,     // memory master sync
  input  wire logic [6:0] regAddr,   // register index
  input  wire logic [15:0] regWdata, // register write data
  input  wire logic     regWr,       // write strobe
  input  wire logic     regRd,       // read strobe
  output logic [15:0]   regRdata     // read data, cycle after strobe
);

  dar_state_t  st_q;
  dar_state_t  st_d;
  logic [21:1] lookBase;
  logic [21:1] swBase;
  logic [4:0]  page;
  logic [4:0]  loEff;
  logic [4:0]  upEff;
  logic        ioPage;
  logic        allReloc;
  logic        inWindow;
  logic        reloc;
  logic        onBoard;
  logic [21:0] passAddr;
  logic [21:0] mappedAddr;
  logic        mapWr;

  ////////////////////////////////////////////////////////////////////////////////
  // base store

  assign mapWr = regWr && (regAddr <= `DAR_IDX_MAP_LAST);

  dar_map_mem #(
    .ENTRIES (32),
    .IDX_W   (5)
  ) u_mem (
    .clk     (clk),
    .rst     (rst),
    .wrEn    (mapWr),                // R15
    .wrHi    (regAddr[0]),
    .wrIdx   (regAddr[5:1]),
    .wrData  (regWdata),
    .rdIdxA  (st_q.bus2.addr[17:13]), // R3
    .rdDataA (lookBase),
    .rdIdxB  (regAddr[5:1]),
    .rdDataB (swBase)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // window decode and address forming

  always_comb begin
    page     = st_q.bus2.addr[17:13];
    ioPage   = (page == `DAR_IO_PAGE);
    loEff    = st_q.forceDef ? `DAR_LIMIT_ZERO : st_q.lo2; // R14
    upEff    = st_q.forceDef ? `DAR_LIMIT_ZERO : st_q.up2; // R14
    allReloc = (loEff == `DAR_LIMIT_ZERO && upEff == `DAR_LIMIT_ZERO)
            || (loEff == `DAR_LIMIT_TOP && upEff == `DAR_LIMIT_TOP)
            || (loEff > upEff);                               // R12
    inWindow = allReloc || (page < loEff) || (page >= upEff); // R9 R10 R11
    reloc    = st_q.mapEn && !ioPage && inWindow;             // R7 R8 R13
    onBoard  = (st_q.bus2.addr >= `DAR_MAPWIN_FIRST && st_q.bus2.addr <= `DAR_MAPWIN_LAST)
            || st_q.bus2.addr == `DAR_LMA_BUS_LO
            || st_q.bus2.addr == `DAR_LMA_BUS_HI;
    passAddr = ioPage ? {`DAR_IO_HIGH, st_q.bus2.addr}     // R13
                      : {`DAR_LOW_HIGH, st_q.bus2.addr};   // R19
    mappedAddr = {lookBase + {9'h000, st_q.bus2.addr[12:1]},
                  st_q.bus2.addr[0]};                       // R1 R4 R5
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d      = st_q;
    st_d.bus1 = busIn;
    st_d.bus2 = st_q.bus1;
    st_d.lo1  = lowerLimit;
    st_d.lo2  = st_q.lo1;
    st_d.up1  = upperLimit;
    st_d.up2  = st_q.up1;

    unique case (st_q.fsm)
      DAR_IDLE: begin
        if (st_q.bus2.msyn && onBoard) begin
          st_d.fsm = DAR_SYNC;                  // R17
        end else if (st_q.bus2.msyn && reloc) begin
          st_d.fsm = DAR_LOOK;                  // R16
        end else if (st_q.bus2.msyn) begin
          st_d.fsm     = DAR_SYNC;
          st_d.memAddr = passAddr;              // R19
          st_d.memCtl  = st_q.bus2.ctl;
          st_d.memMsyn = 1'b1;
        end
      end
      DAR_LOOK: begin
        st_d.fsm     = DAR_SYNC;
        st_d.memAddr = mappedAddr;              // R6
        st_d.memCtl  = st_q.bus2.ctl;           // R5
        st_d.last_mapped_address     = mappedAddr;              // R6
        st_d.lmaCtl  = st_q.bus2.ctl;
        st_d.memMsyn = 1'b1;                    // R16
      end
      DAR_SYNC: begin
        if (!st_q.bus2.msyn) begin
          st_d.fsm     = DAR_IDLE;
          st_d.memMsyn = 1'b0;
        end
      end
      default: begin
        st_d.fsm     = DAR_IDLE;
        st_d.memMsyn = 1'b0;
      end
    endcase

    if (regWr && regAddr == `DAR_IDX_STATUS3) begin
      st_d.mapEn = regWdata[`DAR_MAPEN_BIT];    // R7
    end
    if (regWr && regAddr == `DAR_IDX_LMA_HI) begin
      st_d.forceDef = regWdata[`DAR_FORCE_BIT]; // R18
    end

    st_d.rdSel = DAR_RD_HOLD;
    if (regRd && regAddr <= `DAR_IDX_MAP_LAST) begin
      st_d.rdSel = regAddr[0] ? DAR_RD_MAPHI : DAR_RD_MAPLO; // R15
    end
    unique case (regAddr)
      `DAR_IDX_LMA_LO:  st_d.rdHold = st_q.last_mapped_address[15:0];
      `DAR_IDX_LMA_HI:  st_d.rdHold = {st_q.lmaCtl, 7'h00, st_q.forceDef,
                                       st_q.last_mapped_address[21:16]};       // R18
      `DAR_IDX_STATUS3: st_d.rdHold = {10'h000, st_q.mapEn, 5'h00};
      default:          st_d.rdHold = 16'h0000;
    endcase
    if (!regRd) begin
      st_d.rdHold = st_q.rdHold;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '{fsm: DAR_IDLE, rdSel: DAR_RD_HOLD, lo1: `DAR_RST_LIMIT,
                lo2: `DAR_RST_LIMIT, up1: `DAR_RST_LIMIT, up2: `DAR_RST_LIMIT,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign memAddr = st_q.memAddr;
  assign memCtl  = st_q.memCtl;
  assign memMsyn = st_q.memMsyn;

  always_comb begin
    unique case (st_q.rdSel)
      DAR_RD_MAPLO: regRdata = {swBase[15:1], 1'b0};     // R2
      DAR_RD_MAPHI: regRdata = {10'h000, swBase[21:16]};
      default:      regRdata = st_q.rdHold;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  idle_quiet_a: assert property (st_q.fsm == DAR_IDLE |-> !memMsyn) // R16
    else $error("memory sync high while idle");

  sync_after_look_a: assert property ($rose(memMsyn) && $past(st_q.mapEn) && // R16
      $past(reloc) |-> $past(st_q.fsm) == DAR_LOOK)
    else $error("mapped sync without lookup cycle");

  onboard_mute_a: assert property (st_q.fsm == DAR_IDLE && st_q.bus2.msyn && // R17
      onBoard |=> !memMsyn [*2])
    else $error("memory synced on register access");

  adder_sum_a: assert property ($rose(memMsyn) && $past(st_q.fsm) == DAR_LOOK |-> // R4
      memAddr[21:1] == $past(lookBase) + {9'h000, $past(st_q.bus2.addr[12:1])})
    else $error("mapped address sum wrong");

  lma_capture_a: assert property ($rose(memMsyn) && $past(st_q.fsm) == DAR_LOOK |-> // R6
      st_q.last_mapped_address == memAddr && st_q.lmaCtl == memCtl)
    else $error("last mapped address not captured");

  low_pass_a: assert property ($rose(memMsyn) && $past(!st_q.mapEn) && // R5
      $past(page) != `DAR_IO_PAGE |-> memAddr == {`DAR_LOW_HIGH, $past(st_q.bus2.addr)}
      && memCtl == $past(st_q.bus2.ctl))
    else $error("unmapped address altered");

  io_page_a: assert property ($rose(memMsyn) && $past(ioPage) |-> // R13
      memAddr == {`DAR_IO_HIGH, $past(st_q.bus2.addr)})
    else $error("I/O page not passed to memory I/O page");

  force_all_a: assert property (st_q.forceDef && st_q.mapEn && !ioPage |-> reloc) // R14
    else $error("force default did not relocate");

  lower_window_a: assert property (!st_q.forceDef && st_q.mapEn && !ioPage && // R10
      st_q.lo2 <= st_q.up2 && page < st_q.lo2 |-> reloc)
    else $error("lower window page not relocated");

  base_bit0_a: assert property (regRd && regAddr <= `DAR_IDX_MAP_LAST && !regAddr[0] // R2
      |=> regRdata[0] == 1'b0)
    else $error("map base bit 0 not zero");

  release_a: assert property (memMsyn && !st_q.bus2.msyn |=> !memMsyn)
    else $error("memory sync not released");

  mapped_c: cover property ($rose(memMsyn) && $past(st_q.fsm) == DAR_LOOK);
  passed_c: cover property ($rose(memMsyn) && $past(st_q.fsm) == DAR_IDLE);
  onboard_c: cover property (st_q.fsm == DAR_IDLE && st_q.bus2.msyn && onBoard);
  maprd_c: cover property (regWr && regAddr == `DAR_IDX_MAP_LAST ##1
      regRd && regAddr == `DAR_IDX_MAP_LAST);

endmodule : dar_reloc_map

// >>> test/dar_bus_master.sv
// bus master model driving the device-side bus pins
`timescale 1ns/100ps
module dar_bus_master
  import dar_pkg::*;
(
  input  wire logic clk,      // system clock
  input  wire logic memMsyn,  // memory master sync
  output dar_bus_t  busOut    // bus pins to the map
);
  initial busOut = '0;
  ////////////////////////////////////////////////////////////////
  // one transfer; n counts edges to memory sync, 12 means none
  task automatic xfer(input logic [17:0] a, input logic [1:0] c, output int n);
    @(posedge clk);
    busOut.addr <= a;
    busOut.ctl  <= c;
    @(posedge clk);
    busOut.msyn <= 1'b1;
    n = 0;
    while (n < 12 && memMsyn !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    busOut.msyn <= 1'b0;
    repeat (4) @(posedge clk);
    // released lines drift away from the last value
    busOut.addr <= ~a;
    busOut.ctl  <= ~c;
  endtask : xfer
endmodule : dar_bus_master

// >>> test/dar_reloc_map_tb.sv
// self-checking bench of the relocation map
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module dar_reloc_map_tb
  import dar_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  dar_bus_t    busIn;
  logic [4:0]  lowerLimit = 5'h00;
  logic [4:0]  upperLimit = 5'h00;
  logic [21:0] memAddr;
  logic [1:0]  memCtl;
  logic        memMsyn;
  logic [6:0]  regAddr = 7'h00;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  dar_reloc_map DUT (.clk(clk), .rst(rst), .busIn(busIn), .lowerLimit(lowerLimit),
    .upperLimit(upperLimit), .memAddr(memAddr), .memCtl(memCtl), .memMsyn(memMsyn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  dar_bus_master bm (.clk(clk), .memMsyn(memMsyn), .busOut(busIn));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] loW(input logic [4:0] i);
    return {i[3:0], 12'hf01};
  endfunction : loW
  function automatic logic [15:0] hiW(input logic [4:0] i);
    return {11'h7fe, i};
  endfunction : hiW
  function automatic logic [21:0] rel(input logic [17:0] a);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = loW(a[17:13]);
    hi = hiW(a[17:13]);
    return {hi[5:0], lo[15:1], 1'b0} + {9'h000, a[12:0]};
  endfunction : rel
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr
  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    `CHK(regRdata, e)
  endtask : rc
  task automatic tx(input logic [17:0] a, input logic [1:0] c, input logic [21:0] e,
                    input int l);
    int n;
    bm.xfer(a, c, n);
    `CHK(memAddr, e)
    `CHK(memCtl, c)
    if (l > 0) `CHK(n, l)
  endtask : tx
  task automatic lim(input logic [4:0] lo, input logic [4:0] up);
    @(posedge clk);
    lowerLimit <= lo;
    upperLimit <= up;
    repeat (4) @(posedge clk);
  endtask : lim
  ////////////////////////////////////////////////////////////////
  task automatic t_map();
    rc(7'h40, 16'h0000);
    rc(7'h41, 16'h0000);
    rc(7'h42, 16'h0000);
    rc(7'h50, 16'h0000);
    for (int i = 0; i < 32; i++) begin
      wr(7'(2 * i), loW(5'(i)));
      wr(7'(2 * i + 1), hiW(5'(i)));
    end
    for (int i = 0; i < 32; i++) begin
      rc(7'(2 * i), loW(5'(i)) & 16'hfffe);
      rc(7'(2 * i + 1), hiW(5'(i)) & 16'h003f);
    end
    $display("test map registers done");
  endtask : t_map
  task automatic t_off();
    tx(18'h0_6abd, 2'b10, {4'h0, 18'h0_6abd}, 3);
    tx(18'h3_e010, 2'b01, {4'hf, 18'h3_e010}, 0);
    $display("test map disabled done");
  endtask : t_off
  task automatic t_all();
    logic [21:0] e;
    e = rel({5'd27, 13'h1fff});
    wr(7'h42, 16'h0020);
    rc(7'h42, 16'h0020);
    tx({5'd27, 13'h1fff}, 2'b01, e, 4);
    rc(7'h40, e[15:0]);
    rc(7'h41, {2'b01, 8'h00, e[21:16]});
    lim(5'd31, 5'd31);
    tx({5'd10, 13'h0123}, 2'b11, rel({5'd10, 13'h0123}), 4);
    lim(5'd20, 5'd8);
    tx({5'd10, 13'h0124}, 2'b00, rel({5'd10, 13'h0124}), 4);
    $display("test relocate all done");
  endtask : t_all
  task automatic t_win();
    int pg[7] = '{2, 3, 4, 10, 23, 24, 27};
    bit rl[7] = '{1, 1, 0, 0, 0, 1, 1};
    logic [17:0] a;
    lim(5'd4, 5'd24);
    tx(18'h3_e010, 2'b01, {4'hf, 18'h3_e010}, 0);
    for (int k = 0; k < 7; k++) begin
      a = {5'(pg[k]), 13'h0abc};
      tx(a, 2'b00, rl[k] ? rel(a) : {4'h0, a}, 0);
    end
    $display("test windows done");
  endtask : t_win
  task automatic t_force();
    logic [21:0] e;
    e = rel({5'd27, 13'h0abc});
    wr(7'h41, 16'h0040);
    rc(7'h41, {2'b00, 7'h00, 1'b1, e[21:16]});
    tx({5'd10, 13'h0456}, 2'b10, rel({5'd10, 13'h0456}), 4);
    wr(7'h41, 16'h0000);
    tx({5'd10, 13'h0456}, 2'b10, {4'h0, 5'd10, 13'h0456}, 0);
    $display("test force default done");
  endtask : t_force
  task automatic t_ref();
    logic [17:0] ra[4] = '{18'h3_f080, 18'h3_f0ff, 18'h3_ffdc, 18'h3_ffde};
    int n;
    for (int k = 0; k < 4; k++) begin
      bm.xfer(ra[k], 2'b00, n);
      `CHK(n, 12)
    end
    $display("test register window done");
  endtask : t_ref
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_map();
    t_off();
    t_all();
    t_win();
    t_force();
    t_ref();
    close_out();
  end
endmodule : dar_reloc_map_tb
